// ==== hdl/ext_bus_defines.vh ====
// constants for the external memory bus edge-timing engine
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EB_OFS_CTRL     5'h00
`define EB_OFS_EDGE     5'h04
`define EB_OFS_ADDR     5'h08
`define EB_OFS_WDATA    5'h0c
`define EB_OFS_STATUS   5'h10
`define EB_OFS_RDATA    5'h14
`define EB_OFS_BITS     5
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define EB_CTRL_START   0
`define EB_CTRL_WRITE   1
`define EB_CTRL_MUX     2
`define EB_CTRL_SYNC    3
`define EB_CTRL_CS_LO   4
`define EB_CTRL_CS_HI   5
`define EB_CTRL_BE_LO   8
`define EB_CTRL_BE_HI   11
`define EB_CTRL_WAIT_LO 16
`define EB_CTRL_WAIT_HI 19
// ----------------------------------------------------------------
// edge select register: 1 means falling edge
// ----------------------------------------------------------------
`define EB_EDGE_CS_ON   0
`define EB_EDGE_CS_OFF  1
`define EB_EDGE_OE_ON   2
`define EB_EDGE_OE_OFF  3
`define EB_EDGE_RW_ON   4
`define EB_EDGE_RW_OFF  5
`define EB_EDGE_BE_ON   6
`define EB_EDGE_BE_OFF  7
`define EB_EDGE_AV_ON   8
`define EB_EDGE_AV_OFF  9
`define EB_EDGE_ADR_END 10
`define EB_EDGE_WD_ON   11
`define EB_EDGE_BITS    12
// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define EB_STAT_BUSY    0
`define EB_STAT_DONE    1
`define EB_STAT_EOB     2
// ----------------------------------------------------------------
// bus clock divider: half period in system clocks
// ----------------------------------------------------------------
`define EB_HALF_NS      20
`define EB_SYS_NS       5
`define EB_HALF_CYC     (`EB_HALF_NS / `EB_SYS_NS)
`define EB_DIV_BITS     3
`define EB_WAIT_BITS    4
`endif

// ==== hdl/bus_sync2.v ====
// two-flop synchroniser for a group of pin inputs
module bus_sync2 #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta_reg;
   // first stage feeds only the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b0}};
         dout     <= {W{1'b0}};
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule

// ==== hdl/ext_bus_edge.v ====
// external memory bus engine with per-strobe edge placement
//
// Behaviour
// [R01] each control strobe turns on and off at its own chosen bus clock edge (CS, OE, RW, BE here all turn off at the falling edge after ack)
// [R02] a new address always starts being driven at a bus clock falling edge
// [R03] in muxed mode the address phase ends on the configured edge (here reads only; a write holds the address until write data starts)
// [R04] non-muxed write data starts at a bus clock rising edge
// [R05] muxed write data starts on the configured bus clock edge
// [R06] read data, end-of-burst and transfer ack are sampled at rising edges
// [R07] sync mode: end-of-burst moves the read sample point to falling edge
// [R08] the block makes the bus clock and keeps it running during accesses
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`include "ext_bus_defines.vh"
module ext_bus_edge (
   input  wire        CLK_SYS,
   input  wire        RST_N,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [4:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output wire        WB_ACK_O,
   output reg         BUS_CLK,
   output reg  [23:0] ADDR,
   output reg         CS_N,
   output reg         RW_N,
   output reg         OE_N,
   output reg  [3:0]  BYTE_ENABLE_N,
   output reg         ADDRESS_VALID_STROBE_N,
   output reg  [31:0] DATA_O,
   output reg         DATA_OE,
   input  wire [31:0] DATA_I,
   input  wire        END_OF_BURST_IN_N,
   input  wire        TRANSFER_ACK_IN,
   input  wire        CLOCKED_CAPTURE_SELECT
);
   // ----------------------------------------------------------------
   // wishbone slave and registers
   // ----------------------------------------------------------------
   reg  [31:0] ctrl_reg;
   reg  [`EB_EDGE_BITS-1:0] edge_reg;
   reg  [23:0] addr_cfg_reg;
   reg  [31:0] wdata_reg;
   reg  [31:0] rdata_reg;
   reg         done_reg;
   reg         eob_seen_reg;
   reg         ack_reg;
   reg         start_reg;
   wire        busy;
   wire        wb_hit  = WB_CYC_I & WB_STB_I & ~ack_reg;
   wire        wb_wr   = wb_hit & WB_WE_I;
   wire [4:0]  ofs     = {WB_ADR_I[4:2], 2'b00};
   wire [31:0] be_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}},
                          {8{WB_SEL_I[0]}}};
   wire        acc_end;
   assign WB_ACK_O = ack_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ack_reg      <= 1'b0;
         ctrl_reg     <= 32'h0000_0000;
         edge_reg     <= {`EB_EDGE_BITS{1'b0}};
         addr_cfg_reg <= 24'h00_0000;
         wdata_reg    <= 32'h0000_0000;
         start_reg    <= 1'b0;
         done_reg     <= 1'b0;
         WB_DAT_O     <= 32'h0000_0000;
      end else begin
         ack_reg   <= wb_hit;
         start_reg <= 1'b0;
         // completion wins over a software clear in the same cycle
         if (acc_end)
            done_reg <= 1'b1;
         else if (wb_wr && ofs == `EB_OFS_STATUS && WB_SEL_I[0] &&
                  WB_DAT_I[`EB_STAT_DONE])
            done_reg <= 1'b0;
         if (wb_wr) begin
            case (ofs)
               `EB_OFS_CTRL: begin
                  ctrl_reg <= (ctrl_reg & ~be_mask) | (WB_DAT_I & be_mask);
                  if (WB_SEL_I[0] && WB_DAT_I[`EB_CTRL_START] && !busy)
                     start_reg <= 1'b1;
               end
               `EB_OFS_EDGE:
                  edge_reg <= (edge_reg & be_mask[`EB_EDGE_BITS-1:0] ^ edge_reg) |
                              (WB_DAT_I[`EB_EDGE_BITS-1:0] & be_mask[`EB_EDGE_BITS-1:0]);
               `EB_OFS_ADDR:
                  addr_cfg_reg <= (addr_cfg_reg & ~be_mask[23:0]) |
                                  (WB_DAT_I[23:0] & be_mask[23:0]);
               `EB_OFS_WDATA:
                  wdata_reg <= (wdata_reg & ~be_mask) | (WB_DAT_I & be_mask);
               default: begin
               end
            endcase
         end
         case (ofs)
            `EB_OFS_CTRL:   WB_DAT_O <= {ctrl_reg[31:1], 1'b0};
            `EB_OFS_EDGE:   WB_DAT_O <= {20'h0_0000, edge_reg};
            `EB_OFS_ADDR:   WB_DAT_O <= {8'h00, addr_cfg_reg};
            `EB_OFS_WDATA:  WB_DAT_O <= wdata_reg;
            `EB_OFS_STATUS: WB_DAT_O <= {29'h0000_0000, eob_seen_reg, done_reg, busy};
            `EB_OFS_RDATA:  WB_DAT_O <= rdata_reg;
            default:        WB_DAT_O <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin input synchronisers
   // ----------------------------------------------------------------
   wire [31:0] data_s;
   wire        eob_n_s;
   wire        ack_s;
   wire        fce_s;
   bus_sync2 #(.W(35)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .din   ({DATA_I, END_OF_BURST_IN_N, TRANSFER_ACK_IN, CLOCKED_CAPTURE_SELECT}),
      .dout  ({data_s, eob_n_s, ack_s, fce_s})
   );

   // ----------------------------------------------------------------
   // bus clock divider
   // ----------------------------------------------------------------
   // free running so every edge is defined even between accesses
   reg [`EB_DIV_BITS-1:0] div_reg;
   wire half_tick = (div_reg == `EB_HALF_CYC - 1);
   wire rise_en   = half_tick & ~BUS_CLK;
   wire fall_en   = half_tick & BUS_CLK;
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= {`EB_DIV_BITS{1'b0}};
         BUS_CLK <= 1'b0;
      end else begin
         div_reg <= half_tick ? {`EB_DIV_BITS{1'b0}} : div_reg + 1'b1;
         if (half_tick)
            BUS_CLK <= ~BUS_CLK; // [R08]
      end
   end

   // ----------------------------------------------------------------
   // access sequencer, counted in bus clock edges
   // ----------------------------------------------------------------
   localparam ST_IDLE = 4'b0001;
   localparam ST_WAIT = 4'b0010;
   localparam ST_ADDR = 4'b0100;
   localparam ST_DATA = 4'b1000;
   reg  [3:0] state_reg;
   reg  [3:0] state_next;
   reg  [`EB_WAIT_BITS-1:0] wait_reg;
   reg        pend_reg;
   reg        is_wr_reg;
   reg        is_mux_reg;
   reg        is_sync_reg;
   reg        ackd_reg;
   wire       eob_now = ~eob_n_s;
   assign busy    = (state_reg != ST_IDLE) | pend_reg;
   assign acc_end = (state_reg == ST_DATA) & (rise_en | fall_en) & ackd_reg;
   wire   active  = (state_reg == ST_ADDR) | (state_reg == ST_DATA);

   // ----------------------------------------------------------------
   // edge chooser: sel high means the falling edge
   // ----------------------------------------------------------------
   // one shared test keeps every strobe's edge choice decoded the same way
   function edge_hit;
      input sel;
      input r;
      input f;
      begin
         edge_hit = sel ? f : r;
      end
   endfunction

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (pend_reg && fall_en) state_next = ST_ADDR; // [R02]
         ST_ADDR: if (rise_en) state_next = ST_DATA;
         ST_DATA: if (acc_end) state_next = ST_IDLE;
         ST_WAIT: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // pin drivers, all registered so each moves with one bus clock edge
   // ----------------------------------------------------------------
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg    <= ST_IDLE;
         pend_reg     <= 1'b0;
         is_wr_reg    <= 1'b0;
         is_mux_reg   <= 1'b0;
         is_sync_reg  <= 1'b0;
         wait_reg     <= {`EB_WAIT_BITS{1'b0}};
         ackd_reg     <= 1'b0;
         eob_seen_reg <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
         ADDR         <= 24'h00_0000;
         CS_N         <= 1'b1;
         RW_N         <= 1'b1;
         OE_N         <= 1'b1;
         BYTE_ENABLE_N <= 4'hf;
         ADDRESS_VALID_STROBE_N <= 1'b1;
         DATA_O       <= 32'h0000_0000;
         DATA_OE      <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start_reg) begin
            pend_reg    <= 1'b1;
            is_wr_reg   <= ctrl_reg[`EB_CTRL_WRITE];
            is_mux_reg  <= ctrl_reg[`EB_CTRL_MUX];
            is_sync_reg <= ctrl_reg[`EB_CTRL_SYNC];
         end
         // ----------------------------------------------------------------
         // launch of a new access
         // ----------------------------------------------------------------
         // address and wait count are frozen here; byte enables, write data and edge selects are still read live mid-access
         if (state_reg == ST_IDLE && state_next == ST_ADDR) begin
            pend_reg     <= 1'b0;
            ADDR         <= addr_cfg_reg; // [R02]
            wait_reg     <= ctrl_reg[`EB_CTRL_WAIT_HI:`EB_CTRL_WAIT_LO];
            ackd_reg     <= 1'b0;
            eob_seen_reg <= 1'b0;
            if (is_mux_reg) begin
               DATA_O  <= {8'h00, addr_cfg_reg};
               DATA_OE <= 1'b1;
            end
         end
         // muxed read address phase ends on the configured edge
         if (active && is_mux_reg && DATA_OE && !is_wr_reg &&
             edge_hit(edge_reg[`EB_EDGE_ADR_END], rise_en, fall_en))
            DATA_OE <= 1'b0; // [R03]
         // write data launch edge depends on mode
         if (state_reg == ST_DATA && is_wr_reg &&
             (is_mux_reg ? edge_hit(edge_reg[`EB_EDGE_WD_ON], rise_en, fall_en)
                         : rise_en)) begin
            DATA_O  <= wdata_reg; // [R04] [R05]
            DATA_OE <= 1'b1;
         end
         // ----------------------------------------------------------------
         // strobes: each on at its own chosen edge, address valid off at its own too
         // ----------------------------------------------------------------
         if (active) begin
            if (edge_hit(edge_reg[`EB_EDGE_CS_ON], rise_en, fall_en))
               CS_N <= 1'b0; // [R01]
            if (edge_hit(edge_reg[`EB_EDGE_RW_ON], rise_en, fall_en))
               RW_N <= ~is_wr_reg; // [R01]
            if (!is_wr_reg && edge_hit(edge_reg[`EB_EDGE_OE_ON], rise_en, fall_en))
               OE_N <= 1'b0; // [R01]
            if (edge_hit(edge_reg[`EB_EDGE_BE_ON], rise_en, fall_en))
               BYTE_ENABLE_N <= ~ctrl_reg[`EB_CTRL_BE_HI:`EB_CTRL_BE_LO]; // [R01]
         end
         // the address phase holds only one rise, so a falling choice opens with the address
         if ((state_reg == ST_ADDR || (state_reg == ST_IDLE && state_next == ST_ADDR)) &&
             edge_hit(edge_reg[`EB_EDGE_AV_ON], rise_en, fall_en))
            ADDRESS_VALID_STROBE_N <= 1'b0; // [R01]
         if (state_reg == ST_DATA &&
             edge_hit(edge_reg[`EB_EDGE_AV_OFF], rise_en, fall_en))
            ADDRESS_VALID_STROBE_N <= 1'b1; // [R01]
         // ----------------------------------------------------------------
         // data phase: wait states, then ack sampling; end-of-burst sampled at every rise, wait states included
         // ----------------------------------------------------------------
         if (state_reg == ST_DATA && rise_en) begin
            if (wait_reg != {`EB_WAIT_BITS{1'b0}})
               wait_reg <= wait_reg - 1'b1;
            else if (ack_s || is_sync_reg) begin
               ackd_reg <= 1'b1; // [R06]
               if (!(is_sync_reg && eob_now))
                  rdata_reg <= data_s; // [R06]
            end
            if (eob_now)
               eob_seen_reg <= 1'b1; // [R06]
         end
         // end-of-burst in sync mode moves the capture to the falling edge
         if (state_reg == ST_DATA && fall_en && is_sync_reg && eob_seen_reg &&
             !is_wr_reg)
            rdata_reg <= data_s; // [R07]
         if (ackd_reg && state_reg == ST_DATA) begin
            if (edge_hit(edge_reg[`EB_EDGE_CS_OFF], rise_en, fall_en))
               CS_N <= 1'b1; // [R01]
            if (edge_hit(edge_reg[`EB_EDGE_OE_OFF], rise_en, fall_en))
               OE_N <= 1'b1; // [R01]
            if (edge_hit(edge_reg[`EB_EDGE_RW_OFF], rise_en, fall_en))
               RW_N <= 1'b1; // [R01]
            if (edge_hit(edge_reg[`EB_EDGE_BE_OFF], rise_en, fall_en))
               BYTE_ENABLE_N <= 4'hf; // [R01]
         end
         // ----------------------------------------------------------------
         // close of access
         // ----------------------------------------------------------------
         // cleanup guarantees every strobe is idle once the access closes
         if (acc_end) begin
            CS_N    <= 1'b1;
            OE_N    <= 1'b1;
            RW_N    <= 1'b1;
            BYTE_ENABLE_N <= 4'hf;
            ADDRESS_VALID_STROBE_N <= 1'b1;
            DATA_OE <= 1'b0;
         end
      end
   end
endmodule

// ==== testbench/ext_bus_edge_sva.sv ====
// assertion checker for the external bus edge engine
`include "ext_bus_defines.vh"
module ext_bus_edge_sva (
   input wire        CLK_SYS,
   input wire        RST_N,
   input wire        WB_CYC_I,
   input wire        WB_STB_I,
   input wire        WB_WE_I,
   input wire [4:0]  WB_ADR_I,
   input wire [31:0] WB_DAT_I,
   input wire        WB_ACK_O,
   input wire        BUS_CLK,
   input wire [23:0] ADDR,
   input wire        CS_N,
   input wire        RW_N,
   input wire        OE_N,
   input wire        ADDRESS_VALID_STROBE_N,
   input wire [31:0] DATA_O,
   input wire        DATA_OE
);
   // mirror of mux bit and edge selects, taken at the acked write
   reg        mux_reg;
   reg [11:0] edge_reg;
   wire       wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mux_reg  <= 1'b0;
         edge_reg <= 12'h000;
      end else if (wr && WB_ADR_I == 5'h00) begin
         mux_reg <= WB_DAT_I[`EB_CTRL_MUX];
      end else if (wr && WB_ADR_I == 5'h04) begin
         edge_reg <= WB_DAT_I[11:0];
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held too long");
   AST_ACK_ANSWER: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
   AST_BCLK_HIGH: assert property ($rose(BUS_CLK) |=> BUS_CLK [*3] ##1 !BUS_CLK)
      else $error("bus clock high width");
   AST_BCLK_LOW: assert property ($fell(BUS_CLK) |=> !BUS_CLK [*3] ##1 BUS_CLK)
      else $error("bus clock low width");
   AST_ADDR_FALL: assert property ($changed(ADDR) |-> !BUS_CLK)
      else $error("address moved off falling edge");
   AST_WD_RISE: assert property ($rose(DATA_OE) && !mux_reg |-> BUS_CLK)
      else $error("write data off rising edge");
   AST_MUX_ADR_END: assert property (mux_reg && $fell(DATA_OE) && $past(RW_N) && RW_N
      |-> BUS_CLK == !edge_reg[`EB_EDGE_ADR_END]) else $error("address phase end edge");
   AST_MUX_WD: assert property (mux_reg && !RW_N && $past(DATA_OE) && DATA_OE
      && $changed(DATA_O) |-> BUS_CLK == !edge_reg[`EB_EDGE_WD_ON])
      else $error("muxed write data edge");
   AST_CS_ON: assert property ($fell(CS_N) |-> BUS_CLK == !edge_reg[`EB_EDGE_CS_ON])
      else $error("select edge");
   AST_OE_ON: assert property ($fell(OE_N) |-> BUS_CLK == !edge_reg[`EB_EDGE_OE_ON])
      else $error("output enable edge");
   AST_RW_ON: assert property ($fell(RW_N) |-> BUS_CLK == !edge_reg[`EB_EDGE_RW_ON])
      else $error("write strobe edge");
   AST_AV_ON: assert property ($fell(ADDRESS_VALID_STROBE_N)
      |-> BUS_CLK == !edge_reg[`EB_EDGE_AV_ON]) else $error("address valid edge");
endmodule

// ==== testbench/ext_mem_model.sv ====
// behavioural external memory on the far side of the bus
module ext_mem_model (
   input  wire         bclk,
   input  wire  [23:0] addr,
   input  wire         cs_n,
   input  wire         rw_n,
   input  wire         oe_n,
   input  wire  [3:0]  be_n,
   input  wire         avs_n,
   input  wire  [31:0] dout,
   input  wire         mux,
   input  wire  [1:0]  lat,
   output logic [31:0] din,
   output logic        ack = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] la = 24'h0;
   logic [23:0] adr_q = 24'h0;
   logic [31:0] wr_q = 32'h0;
   logic [3:0]  be_q = 4'h0;
   logic [1:0]  cnt = 2'h0;
   int          n = 0;
   wire  [23:0] av = mux ? la : addr;
   // a released bus shows the inverse, so a late sample cannot pass by luck
   assign din = oe_n ? ~{8'ha5, av} : {8'ha5, av};
   always @(negedge cs_n) n++;
   // sampled just after the edge: strobes moving on that edge race the clock
   always @(posedge bclk) begin
      #1;
      if (!avs_n) la <= dout[23:0];
      if (!cs_n) adr_q <= av;
      if (!cs_n && !rw_n) begin
         wr_q <= dout;
         be_q <= be_n;
      end
   end
   // ack moves on the falling edge, clear of the rising sample point
   always @(negedge bclk) begin
      #1;
      if (cs_n) begin
         cnt <= 2'h0;
         ack <= 1'b0;
      end else if (cnt == lat) ack <= 1'b1;
      else cnt <= cnt + 2'h1;
   end
endmodule

// ==== testbench/external_bus_edge_timing_tb.sv ====
// self-checking bench for the external bus edge engine
module external_bus_edge_timing_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] dat = 32'h0;
   logic        eob_n = 1'b1;
   logic        mux = 1'b0;
   logic [1:0]  lat = 2'h0;
   logic [31:0] rd, wd;
   logic [23:0] a;
   int          mismatches = 0;
   int          comparisons = 0;
   int          n0;
   wire  [31:0] wb_rd, d_o, d_i;
   wire  [23:0] a_o;
   wire  [3:0]  be_n;
   wire         ack, bclk, cs_n, rw_n, oe_n, avs_n, d_oe, t_ack;
   // rows: control, edge selects, memory latency, end-of-burst
   logic [31:0] r_ctrl [6] = '{32'h00020f00, 32'h00000302, 32'h00000f06,
                               32'h00010f04, 32'h00000f08, 32'h00000c0a};
   logic [11:0] r_edge [6] = '{12'h000, 12'hfff, 12'hc00, 12'h400, 12'h155, 12'h2aa};
   logic [1:0]  r_lat [6]  = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
   logic [5:0]  r_eob      = 6'h10;
   ext_bus_edge DUT (
      .CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(wb_rd), .WB_ACK_O(ack),
      .BUS_CLK(bclk), .ADDR(a_o), .CS_N(cs_n), .RW_N(rw_n), .OE_N(oe_n),
      .BYTE_ENABLE_N(be_n), .ADDRESS_VALID_STROBE_N(avs_n), .DATA_O(d_o),
      .DATA_OE(d_oe), .DATA_I(d_i), .END_OF_BURST_IN_N(eob_n),
      .TRANSFER_ACK_IN(t_ack), .CLOCKED_CAPTURE_SELECT(1'b0));
   ext_mem_model pm (
      .bclk(bclk), .addr(a_o), .cs_n(cs_n), .rw_n(rw_n), .oe_n(oe_n), .be_n(be_n),
      .avs_n(avs_n), .dout(d_o), .mux(mux), .lat(lat), .din(d_i), .ack(t_ack));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ----
   // tasks
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // held until the edge that sees ack, then released
   task automatic wb(input logic w, input logic [4:0] ad, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= ad;
      dat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k == 20) begin
         mismatches++;
         test_done;
      end
      rd = wb_rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      do begin
         wb(1'b0, 5'h10, 32'h0);
         k++;
      end while (rd[1] !== 1'b1 && k < 100);
      chk({31'h0, rd[1]}, 32'h1);
   endtask
   task automatic chk_idle;
      chk({23'h0, cs_n, rw_n, oe_n, avs_n, be_n, d_oe}, 32'h000001fe);
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (3) @(posedge clk);
      chk_idle;
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         a = {20'h12340, i[3:0]};
         wd = {28'hc0de123, i[3:0]};
         mux <= r_ctrl[i][2];
         lat <= r_lat[i];
         eob_n <= !r_eob[i];
         wb(1'b1, 5'h04, {20'h0, r_edge[i]});
         wb(1'b1, 5'h08, {8'h0, a});
         wb(1'b1, 5'h0c, wd);
         wb(1'b1, 5'h00, r_ctrl[i] | 32'h1);
         wait_done;
         chk({31'h0, rd[2]}, {31'h0, r_eob[i]});
         wb(1'b1, 5'h10, 32'h2);
         chk({8'h0, pm.adr_q}, {8'h0, a});
         if (r_ctrl[i][1]) begin
            chk(pm.wr_q, wd);
            chk({28'h0, pm.be_q}, {28'h0, ~r_ctrl[i][11:8]});
         end else begin
            wb(1'b0, 5'h14, 32'h0);
            chk(rd, {8'ha5, a});
         end
         $display("row %0d done", i);
      end
      wb(1'b1, 5'h18, 32'hffffffff);
      wb(1'b0, 5'h18, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 5'h00, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      wb(1'b0, 5'h10, 32'h0);
      chk({31'h0, rd[1]}, 32'h0);
      n0 = pm.n;
      lat <= 2'h3;
      wb(1'b1, 5'h00, 32'h00030f01);
      wb(1'b1, 5'h00, 32'h00030f01);
      wb(1'b0, 5'h10, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      wait_done;
      // a second start taken while busy would open another select within this span
      repeat (48) @(posedge clk);
      chk(32'(pm.n - n0), 32'h1);
      $display("register cases done");
      wb(1'b1, 5'h00, 32'h00030f01);
      repeat (20) @(posedge clk);
      chk({31'h0, cs_n}, 32'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk_idle;
      rst_n <= 1'b1;
      wb(1'b0, 5'h10, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 5'h04, 32'h0);
      chk(rd, 32'h0);
      $display("reset case done");
      test_done;
   end
   initial begin
      #300000;
      mismatches++;
      test_done;
   end
endmodule
bind ext_bus_edge ext_bus_edge_sva chk_i (.CLK_SYS, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
   .WB_ADR_I, .WB_DAT_I, .WB_ACK_O, .BUS_CLK, .ADDR, .CS_N, .RW_N, .OE_N,
   .ADDRESS_VALID_STROBE_N, .DATA_O, .DATA_OE);
